//--- common/host_port_pkg.sv
package host_port_pkg;
  localparam int          DATA_W        = 13;
  localparam int          CFG_W         = 8;
  localparam int          EVT_W         = 3;
  localparam int          NARROW_W      = 8;
  localparam int          CLK_MHZ       = 125;

  // Register byte addresses
  localparam logic [7:0]  ADDR_CONFIG   = 8'h00;
  localparam logic [7:0]  ADDR_RESULT   = 8'h04;
  localparam logic [7:0]  ADDR_CTRL     = 8'h08;
  localparam logic [7:0]  ADDR_STATUS   = 8'h0C;
  localparam logic [7:0]  ADDR_MASK     = 8'h10;
  localparam logic [7:0]  ADDR_STATE    = 8'h14;

  // Configuration fields
  localparam logic [7:0]  CFG_RESET     = 8'h10;
  localparam int          CFG_SYNC_BIT  = 4;
  localparam int          CFG_WIDTH_BIT = 3;
  localparam logic [12:0] RESULT_RESET  = 13'h0000;

  // Control bits
  localparam int          CTRL_START    = 0;
  localparam int          CTRL_DONE     = 1;
  localparam int          CTRL_READY    = 2;

  // Event bits, shared by status and mask
  localparam int          EVT_HOST_WR   = 0;
  localparam int          EVT_HOST_RD   = 1;
  localparam int          EVT_SYNC      = 2;
  localparam logic [2:0]  EVT_RESET     = 3'h0;
endpackage : host_port_pkg

//--- src/host_port.sv
// Behaviour
// R01 - Latch write edge strap after power-up
// R02 - Strap low: capture on strobe release
// R03 - Strap high: capture on strobe assertion
// R04 - Strap held fixed after power-up
// R05 - Sync mode: sync rising edge starts conversion
// R06 - Async mode: sync output marks conversion
// R07 - Narrow bus: upper five lines undriven
// R08 - Wide bus: all thirteen lines used
// R09 - Thirteen lines, line twelve most significant
// R10 - Write needs select and write strobe
// R11 - Drive bus only on select and read
// R12 - Active low ready output
// R13 - Host keeps clock within range
// R14 - Host writes go to configuration register
// R15 - Host reads return conversion result
// R16 - Narrow read sign extends upper byte
// R17 - Configuration resets to sync mode only
// R18 - Deselected: strobes ignored, bus released
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
module host_port
  import host_port_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic                   irq,
  input  wire logic              sel_n,
  input  wire logic              rd_n,
  input  wire logic              wr_n,
  input  wire logic              write_edge_select,
  input  wire logic [DATA_W-1:0] data_lines_in,
  output logic      [DATA_W-1:0] data_lines_out,
  output logic      [DATA_W-1:0] data_lines_oe_n,
  input  wire logic              sync_in,
  output logic                   sync_out,
  output logic                   sync_oe_n,
  output logic                   ready_n
);

  typedef struct packed {
    logic [CFG_W-1:0]  cfg;
    logic [DATA_W-1:0] result;
    logic              edge_sel;
    logic              strap_done;
    logic              wr_prev;
    logic              rd_prev;
    logic              sync_prev;
    logic [CFG_W-1:0]  wr_hold;
    logic              byte_hi;
    logic              converting;
    logic              ready;
    logic              ready_n;
    logic [EVT_W-1:0]  status;
    logic [EVT_W-1:0]  mask;
    logic              irq;
    logic [DATA_W-1:0] dout;
    logic [DATA_W-1:0] doe_n;
    logic              sync_out;
    logic              sync_oe_n;
    logic              ph_valid;
    logic              ph_write;
    logic [7:0]        ph_addr;
    logic [31:0]       hrdata;
  } state_t;

  state_t s;
  state_t next_s;

  function automatic logic strobe_active(input logic cs_n, input logic strobe_n);
    strobe_active = !cs_n && !strobe_n;
  endfunction : strobe_active

  logic             wr_act;
  logic             rd_act;
  logic             wide;
  logic [EVT_W-1:0] events;
  logic [CFG_W-1:0] bus_byte;
  logic             ahb_wr_cfg;
  logic             ahb_wr_ctrl;

  always_comb begin
    wr_act   = strobe_active(sel_n, wr_n); // [R10] [R18]
    rd_act   = strobe_active(sel_n, rd_n); // [R11] [R18]
    wide     = s.cfg[CFG_WIDTH_BIT];
    bus_byte = data_lines_in[CFG_W-1:0]; // [R07]
    events   = '0;
    next_s   = s;
    ahb_wr_cfg  = s.ph_valid && s.ph_write && s.ph_addr == ADDR_CONFIG;
    ahb_wr_ctrl = s.ph_valid && s.ph_write && s.ph_addr == ADDR_CTRL;

    // Strap caught once at the first enabled edge after release
    if (!s.strap_done) begin
      next_s.edge_sel   = write_edge_select; // [R01]
      next_s.strap_done = 1'b1;
    end

    // Register bus: data phase of the previous address phase
    if (s.ph_valid && s.ph_write) begin
      case (s.ph_addr)
        ADDR_CONFIG: next_s.cfg = hwdata[CFG_W-1:0];
        ADDR_RESULT: next_s.result = hwdata[DATA_W-1:0];
        ADDR_CTRL: begin
          if (hwdata[CTRL_START]) begin
            next_s.converting = 1'b1;
          end
          if (hwdata[CTRL_DONE]) begin
            next_s.converting = 1'b0;
          end
          next_s.ready = hwdata[CTRL_READY];
        end
        ADDR_STATUS: next_s.status = s.status & ~hwdata[EVT_W-1:0];
        ADDR_MASK: next_s.mask = hwdata[EVT_W-1:0];
        default: begin
        end
      endcase
    end

    // Host write capture; the pin side wins over a same-cycle bus write
    next_s.wr_prev = wr_act;
    if (wr_act) begin
      next_s.wr_hold = bus_byte;
    end
    if (s.strap_done) begin
      if (s.edge_sel && wr_act && !s.wr_prev) begin
        next_s.cfg = bus_byte; // [R03] [R14]
        events[EVT_HOST_WR] = 1'b1;
      end else if (!s.edge_sel && !wr_act && s.wr_prev) begin
        next_s.cfg = s.wr_hold; // [R02] [R14]
        events[EVT_HOST_WR] = 1'b1;
      end
    end

    // Host read completes on strobe release; narrow reads alternate bytes
    next_s.rd_prev = rd_act;
    if (!rd_act && s.rd_prev) begin
      events[EVT_HOST_RD] = 1'b1;
      next_s.byte_hi = wide ? 1'b0 : !s.byte_hi;
    end

    // Sync pin as trigger input
    next_s.sync_prev = sync_in;
    if (s.cfg[CFG_SYNC_BIT] && sync_in && !s.sync_prev) begin
      next_s.converting = 1'b1; // [R05]
      events[EVT_SYNC] = 1'b1;
    end

    // Set wins over a same-cycle clear
    next_s.status = next_s.status | events;
    next_s.irq    = |(next_s.status & next_s.mask);

    // Data lines, registered so they lag the strobes by one edge
    next_s.dout  = '0;
    next_s.doe_n = '1;
    if (rd_act) begin
      if (next_s.cfg[CFG_WIDTH_BIT]) begin
        next_s.dout  = s.result; // [R08] [R09] [R15]
        next_s.doe_n = '0;
      end else begin
        next_s.dout[NARROW_W-1:0] = s.byte_hi ?
          {{3{s.result[DATA_W-1]}}, s.result[DATA_W-1:NARROW_W]} : // [R16]
          s.result[NARROW_W-1:0];
        next_s.doe_n[NARROW_W-1:0] = '0; // [R07]
      end
    end

    // Sync pin as conversion status output
    next_s.sync_oe_n = next_s.cfg[CFG_SYNC_BIT];
    next_s.sync_out  = !next_s.cfg[CFG_SYNC_BIT] && next_s.converting; // [R06]
    next_s.ready_n   = !next_s.ready; // [R12]

    // Register bus address phase; zero wait, read data ready for data phase
    next_s.ph_valid = hsel && htrans[1] && hready;
    next_s.ph_write = hwrite;
    next_s.ph_addr  = haddr[7:0];
    next_s.hrdata   = '0;
    if (hsel && htrans[1] && hready && !hwrite) begin
      case (haddr[7:0])
        ADDR_CONFIG: next_s.hrdata = {24'h00_0000, s.cfg};
        ADDR_RESULT: next_s.hrdata = {19'h0_0000, s.result};
        ADDR_STATUS: next_s.hrdata = {29'h0000_0000, s.status};
        ADDR_MASK:   next_s.hrdata = {29'h0000_0000, s.mask};
        ADDR_STATE:  next_s.hrdata = {28'h000_0000, s.edge_sel, s.byte_hi,
                                      s.converting, s.ready};
        default:     next_s.hrdata = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s            <= '0;
      s.cfg        <= CFG_RESET; // [R17]
      s.result     <= RESULT_RESET;
      s.status     <= EVT_RESET;
      s.mask       <= EVT_RESET;
      s.doe_n      <= '1;
      s.sync_oe_n  <= 1'b1;
      s.ready_n    <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign hrdata          = s.hrdata;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign irq             = s.irq;
  assign data_lines_out  = s.dout;
  assign data_lines_oe_n = s.doe_n;
  assign sync_out        = s.sync_out;
  assign sync_oe_n       = s.sync_oe_n;
  assign ready_n         = s.ready_n;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_STRAP_FIXED: assert property ( // [R04]
    s.strap_done |=> $stable(s.edge_sel))
    else $error("write edge strap changed after capture");

  AST_WR_RELEASE: assert property ( // [R02]
    ce && s.strap_done && !s.edge_sel && s.wr_prev && !wr_act |=> s.cfg == $past(s.wr_hold))
    else $error("release edge capture missed");

  AST_WR_ASSERT: assert property ( // [R03]
    ce && s.strap_done && s.edge_sel && !s.wr_prev && wr_act
    |=> s.cfg == $past(data_lines_in[7:0]))
    else $error("assert edge capture missed");

  AST_SYNC_TRIGGER: assert property ( // [R05]
    ce && s.cfg[CFG_SYNC_BIT] && sync_in && !s.sync_prev |=> s.converting && s.status[EVT_SYNC])
    else $error("sync edge did not start conversion");

  AST_SYNC_STATUS: assert property ( // [R06]
    !sync_oe_n |-> sync_out == s.converting)
    else $error("sync output does not follow conversion");

  AST_NARROW_FLOAT: assert property ( // [R07]
    !s.cfg[CFG_WIDTH_BIT] |-> &data_lines_oe_n[12:8])
    else $error("upper lines driven in narrow mode");

  AST_READ_DRIVE: assert property ( // [R11]
    ce && rd_act |=> !data_lines_oe_n[0])
    else $error("bus not driven during read");

  AST_DESELECT: assert property ( // [R18]
    ce && sel_n |=> &data_lines_oe_n)
    else $error("bus driven while deselected");

  AST_DESELECT_IGNORE: assert property ( // [R18]
    ce && sel_n && !s.wr_prev && !ahb_wr_cfg |=> $stable(s.cfg))
    else $error("configuration changed while deselected");

  AST_DESELECT_STROBES: assert property ( // [R18]
    ce && sel_n |=> !s.wr_prev && !s.rd_prev)
    else $error("strobe seen while deselected");

  AST_WR_NEEDS_STROBE: assert property ( // [R10]
    ce && !wr_act && !s.wr_prev && !ahb_wr_cfg |=> $stable(s.cfg))
    else $error("configuration changed without write strobe");

  AST_WR_EVENT: assert property ( // [R14]
    ce && s.strap_done && (s.edge_sel ? (wr_act && !s.wr_prev) : (!wr_act && s.wr_prev))
    |=> s.status[EVT_HOST_WR])
    else $error("host write event not flagged");

  AST_STRAP_LATCH: assert property ( // [R01]
    ce && !s.strap_done
    |=> s.strap_done && s.edge_sel == $past(write_edge_select))
    else $error("write edge strap not latched");

  AST_WIDE_READ: assert property ( // [R15]
    ce && rd_act
    |=> !s.cfg[CFG_WIDTH_BIT] || data_lines_out == $past(s.result))
    else $error("wide read returned wrong value");

  AST_WIDE_DRIVE: assert property ( // [R08]
    ce && rd_act |=> !s.cfg[CFG_WIDTH_BIT] || ~|data_lines_oe_n)
    else $error("wide read left lines floating");

  AST_NARROW_LOW: assert property ( // [R15]
    ce && rd_act && !s.byte_hi
    |=> s.cfg[CFG_WIDTH_BIT] || data_lines_out[7:0] == $past(s.result[7:0]))
    else $error("narrow low byte wrong");

  AST_NARROW_HIGH: assert property ( // [R16]
    ce && rd_act && s.byte_hi
    |=> s.cfg[CFG_WIDTH_BIT] || (data_lines_out[7:5] == {3{$past(s.result[12])}}
        && data_lines_out[4:0] == $past(s.result[12:8])))
    else $error("narrow high byte not sign extended");

  AST_READ_RELEASE: assert property ( // [R11]
    ce && !rd_act |=> &data_lines_oe_n)
    else $error("bus still driven after read");

  AST_READ_EVENT: assert property ( // [R11]
    ce && s.rd_prev && !rd_act |=> s.status[EVT_HOST_RD])
    else $error("host read event not flagged");

  AST_BYTE_TOGGLE: assert property ( // [R16]
    ce && s.rd_prev && !rd_act && !s.cfg[CFG_WIDTH_BIT]
    |=> s.byte_hi != $past(s.byte_hi))
    else $error("narrow byte pointer did not advance");

  AST_BYTE_WIDE: assert property ( // [R08]
    ce && s.rd_prev && !rd_act && s.cfg[CFG_WIDTH_BIT] |=> !s.byte_hi)
    else $error("byte pointer not cleared by wide read");

  AST_SYNC_INPUT: assert property ( // [R05]
    s.cfg[CFG_SYNC_BIT] |-> sync_oe_n)
    else $error("sync pin driven in synchronous mode");

  AST_SYNC_IGNORED: assert property ( // [R06]
    ce && !s.cfg[CFG_SYNC_BIT] && sync_in && !s.sync_prev && !ahb_wr_ctrl
    |=> s.converting == $past(s.converting))
    else $error("sync edge acted in asynchronous mode");

  AST_CONV_START: assert property ( // [R06]
    ce && ahb_wr_ctrl && hwdata[CTRL_START] && !hwdata[CTRL_DONE]
    |=> s.converting && (sync_oe_n || sync_out))
    else $error("conversion start not shown");

  AST_CONV_END: assert property ( // [R06]
    ce && ahb_wr_ctrl && hwdata[CTRL_DONE]
    && !(s.cfg[CFG_SYNC_BIT] && sync_in && !s.sync_prev)
    |=> !s.converting && !sync_out)
    else $error("conversion end not shown");

  AST_READY_LEVEL: assert property ( // [R12]
    ce && ahb_wr_ctrl |=> ready_n == !$past(hwdata[CTRL_READY]))
    else $error("ready output does not follow control");

  AST_IRQ_LEVEL: assert property (
    irq == |(s.status & s.mask))
    else $error("interrupt does not match masked status");

endmodule : host_port

//--- verification/host_model.sv
module host_model
  import host_port_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [DATA_W-1:0] bus,
  input  wire logic [DATA_W-1:0] oe_n,
  output logic                   sel_n,
  output logic                   rd_n,
  output logic                   wr_n,
  output logic      [DATA_W-1:0] din,
  output logic                   sync_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {sel_n, rd_n, wr_n} = 3'h7;
    din = '0;
    sync_in = 1'b0;
  end
  task automatic wr_begin(input logic [7:0] d, input logic s);
    @(posedge clk);
    {sel_n, wr_n} <= {s, 1'b0};
    din <= {5'h00, d};
  endtask : wr_begin
  task automatic wr_end();
    @(posedge clk);
    {sel_n, wr_n} <= 2'h3;
    din <= ~din; // Released lines must not keep the byte
  endtask : wr_end
  task automatic rd(output logic [DATA_W-1:0] q, output logic [DATA_W-1:0] e);
    @(posedge clk);
    {sel_n, rd_n} <= 2'h0;
    repeat (3) @(negedge clk);
    q = bus;
    e = oe_n;
    @(posedge clk);
    {sel_n, rd_n} <= 2'h3;
  endtask : rd
  task automatic pulse();
    @(posedge clk);
    sync_in <= 1'b1;
    repeat (3) @(posedge clk);
    sync_in <= 1'b0;
  endtask : pulse
endmodule : host_model

//--- verification/tb_host_port.sv
module tb_host_port;
  import host_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic              hclk;
  logic              hresetn = 1'b0;
  logic              ce = 1'b1;
  logic              hsel = 1'b1;
  logic              hwrite = 1'b0;
  logic [2:0]        hsize = 3'h2;
  logic [1:0]        htrans = 2'h0;
  logic [31:0]       haddr = '0, hwdata = '0, hrdata, q;
  logic              hreadyout, hresp, irq, sel_n, rd_n, wr_n, sync_in, sync_out;
  logic              sync_oe_n, ready_n, write_edge_select = 1'b0;
  logic [DATA_W-1:0] din, data_lines_in, data_lines_out, data_lines_oe_n, hq, he;
  logic [31:0]       ctl[3] = '{32'h1, 32'h2, 32'h4};
  logic [31:0]       ectl[3] = '{32'h3, 32'h1, 32'h0};
  int                n_mismatch = 0, cmp_count = 0;
  assign data_lines_in = (~data_lines_oe_n & data_lines_out) | (data_lines_oe_n & din);
  host_port host_port_i (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq, .sel_n, .rd_n, .wr_n,
    .write_edge_select, .data_lines_in, .data_lines_out, .data_lines_oe_n, .sync_in,
    .sync_out, .sync_oe_n, .ready_n);
  host_model host_model_i (.clk(hclk), .bus(data_lines_in), .oe_n(data_lines_oe_n),
    .sel_n, .rd_n, .wr_n, .din, .sync_in);
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wait_hr();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      final_report();
    end
  endtask : wait_hr
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    wait_hr();
    htrans <= 2'h0;
    hwdata <= d;
    wait_hr();
    r = hrdata;
  endtask : ahb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(a, 1'b0, 32'h0, r);
    chk("ahb read", r, e);
    chk("hresp", 32'(hresp), 32'h0);
  endtask : rchk
  task automatic settle();
    repeat (2) @(negedge hclk);
  endtask : settle
  task automatic do_reset(input logic s);
    hresetn <= 1'b0;
    write_edge_select <= s; // Strap only moves under reset
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask : do_reset
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    final_report();
  end
  initial begin
    do_reset(1'b0);
    rchk(ADDR_CONFIG, 32'h0000_0010);
    rchk(ADDR_RESULT, 32'h0);
    chk("oe_n", 32'(data_lines_oe_n), 32'h0000_1FFF);
    ahb(ADDR_RESULT, 1'b1, 32'h0000_1A5C, q);
    host_model_i.rd(hq, he);
    chk("low byte", 32'(hq[7:0]), 32'h0000_005C);
    chk("oe_n", 32'(he), 32'h0000_1F00);
    host_model_i.rd(hq, he);
    chk("high byte", 32'(hq[7:0]), 32'h0000_00FA);
    settle();
    chk("oe_n", 32'(data_lines_oe_n), 32'h0000_1FFF);
    host_model_i.wr_begin(8'h08, 1'b1);
    host_model_i.wr_end();
    rchk(ADDR_CONFIG, 32'h0000_0010);
    host_model_i.wr_begin(8'h08, 1'b0);
    rchk(ADDR_CONFIG, 32'h0000_0010);
    host_model_i.wr_end();
    settle();
    rchk(ADDR_CONFIG, 32'h0000_0008);
    chk("sync_oe_n", 32'(sync_oe_n), 32'h0);
    host_model_i.rd(hq, he);
    chk("wide", 32'(hq), 32'h0000_1A5C);
    chk("oe_n", 32'(he), 32'h0);
    foreach (ctl[i]) begin
      ahb(ADDR_CTRL, 1'b1, ctl[i], q);
      settle();
      chk("sync ready", 32'({sync_out, ready_n}), ectl[i]);
    end
    chk("irq", 32'(irq), 32'h0);
    ahb(ADDR_MASK, 1'b1, 32'h3, q);
    settle();
    chk("irq", 32'(irq), 32'h1);
    rchk(ADDR_STATUS, 32'h3);
    ahb(ADDR_STATUS, 1'b1, 32'h3, q);
    settle();
    chk("irq", 32'(irq), 32'h0);
    rchk(8'h20, 32'h0);
    do_reset(1'b1);
    chk("sync_oe_n", 32'(sync_oe_n), 32'h1);
    host_model_i.pulse();
    settle();
    rchk(ADDR_STATE, 32'h0000_000A);
    rchk(ADDR_STATUS, 32'h4);
    host_model_i.wr_begin(8'h18, 1'b0);
    rchk(ADDR_CONFIG, 32'h0000_0018);
    host_model_i.wr_end();
    ahb(ADDR_CONFIG, 1'b1, 32'h0000_0000, q);
    settle();
    chk("sync pin", 32'({sync_oe_n, sync_out}), 32'h1);
    host_model_i.rd(hq, he);
    chk("oe_n", 32'(he), 32'h0000_1F00);
    final_report();
  end
endmodule : tb_host_port
